// ===== hw/lsc_consts.vh
// constants of the led sink control and fault block
`ifndef LSC_CONSTS_VH
`define LSC_CONSTS_VH

// one millisecond of mclk at 200 MHz
`define LSC_MS_CYCLES 200000

// times in milliseconds
`define LSC_SHORT_MASK_MS 11'h004
`define LSC_ON_T0_MS 11'h0C8
`define LSC_ON_T1_MS 11'h258
`define LSC_ON_T2_MS 11'h320
`define LSC_ON_T3_MS 11'h4B0
`define LSC_FILT_MIN_MS 14'h0050
`define LSC_FILT_MAX_MS 14'h2710

// status flag positions
`define LSC_F_BLOFF 0
`define LSC_F_CMP 1
`define LSC_F_CMP2 2
`define LSC_F_OVP 3
`define LSC_F_TSD 4
`define LSC_F_SHORT 5
`define LSC_NFLAGS 6

// fault state codes
`define LSC_ST_STANDBY 3'h0
`define LSC_ST_SOFT 3'h1
`define LSC_ST_RUN 3'h2
`define LSC_ST_SHORT 3'h3
`define LSC_ST_THERMAL 3'h4

`define LSC_NSINKS 7
`define LSC_SINK_W 7

`endif

// ===== hw/lsc_level_filter.v
// comparator level synchroniser and change filter
`include "lsc_consts.vh"
module lsc_level_filter #(
   parameter WIDTH = 4
) (
   input wire mclk,
   input wire arst_n,
   input wire ms_tick,
   input wire [13:0] filter_ms,
   input wire [WIDTH-1:0] level_raw,
   output reg [WIDTH-1:0] level_q
);
   reg [WIDTH-1:0] s1_q;
   reg [WIDTH-1:0] s2_q;
   reg [WIDTH-1:0] s3_q;
   reg [13:0] cnt_q;
   wire agree;
   wire differs;

   assign agree = (s2_q == s3_q);
   assign differs = agree && (s3_q != level_q);

   always @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s1_q <= {WIDTH{1'b0}};
         s2_q <= {WIDTH{1'b0}};
         s3_q <= {WIDTH{1'b0}};
         cnt_q <= 14'h0000;
         level_q <= {WIDTH{1'b0}};
      end
      else
      begin
         s1_q <= level_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // a bounce back to the held value restarts the wait
         if (!differs)
            cnt_q <= 14'h0000;
         else if (cnt_q >= filter_ms)
         begin
            level_q <= s3_q;
            cnt_q <= 14'h0000;
         end
         else if (ms_tick)
            cnt_q <= cnt_q + 14'h0001;
      end
   end
endmodule // lsc_level_filter

// ===== hw/lsc_blink.v
// blink sequencer of one independent sink
`include "lsc_consts.vh"
module lsc_blink (
   input wire mclk,
   input wire arst_n,
   input wire ms_tick,
   input wire enable,
   input wire [1:0] on_code,
   input wire [1:0] off_code,
   output wire sink_on
);
   localparam S_IDLE = 2'h0;
   localparam S_ON = 2'h1;
   localparam S_OFF = 2'h2;

   reg [1:0] state_q;
   reg [10:0] cnt_q;

   // code 0 of the off timer means no blinking
   function [10:0] phase_ms;
      input [1:0] code;
      input is_on;
      begin
         case (code)
            2'h0: phase_ms = is_on ? `LSC_ON_T0_MS : 11'h000;
            2'h1: phase_ms = `LSC_ON_T1_MS;
            2'h2: phase_ms = `LSC_ON_T2_MS;
            default: phase_ms = `LSC_ON_T3_MS;
         endcase
      end
   endfunction

   assign sink_on = (state_q == S_ON);

   always @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_q <= S_IDLE;
         cnt_q <= 11'h000;
      end
      else
      begin
         case (state_q)
            S_IDLE:
            begin
               cnt_q <= 11'h000;
               if (enable)
                  state_q <= S_ON;
            end
            S_ON:
            begin
               if (!enable)
                  state_q <= S_IDLE;
               else if (off_code == 2'h0)
                  cnt_q <= 11'h000;
               else if (cnt_q >= phase_ms(on_code, 1'b1))
               begin
                  state_q <= S_OFF;
                  cnt_q <= 11'h000;
               end
               else if (ms_tick)
                  cnt_q <= cnt_q + 11'h001;
            end
            S_OFF:
            begin
               if (!enable)
                  state_q <= S_IDLE;
               else if (cnt_q >= phase_ms(off_code, 1'b0))
               begin
                  state_q <= S_ON;
                  cnt_q <= 11'h000;
               end
               else if (ms_tick)
                  cnt_q <= cnt_q + 11'h001;
            end
            default:
               state_q <= S_IDLE;
         endcase
      end
   end
endmodule // lsc_blink

// ===== hw/lsc_ctrl.v
// led sink control, ambient level mapping, fault states and interrupt flags
`include "lsc_consts.vh"
module lsc_ctrl #(
   parameter MS_CYCLES = `LSC_MS_CYCLES
) (
   input wire mclk,
   input wire arst_n,
   // level configuration
   input wire auto_level_enable,
   input wire [2:0] manual_level_code,
   input wire [2:0] filter_sel,
   input wire [3:0] level_main_raw,
   input wire [3:0] level_second_raw,
   input wire seventh_sink_ambient_enable,
   input wire [6:0] seventh_level0,
   input wire [6:0] seventh_level1,
   input wire [6:0] seventh_level2,
   input wire [6:0] seventh_level3,
   input wire [6:0] seventh_level4,
   // sinks
   input wire [6:0] seventh_sink_independent_select,
   input wire [6:0] sink_enable_bit,
   input wire [48:0] sink_current,
   input wire [3:0] fade_in_code,
   input wire [3:0] fade_out_code,
   input wire fade_law,
   input wire [1:0] shared_on_timer,
   input wire [13:0] sink_off_timer,
   // faults
   input wire standby_release_bit,
   input wire standby_enter,
   input wire short_detect,
   input wire overvoltage_detect,
   input wire overtemp_detect,
   input wire cooled_detect,
   input wire backlight_fade_done,
   // interrupt flags
   input wire [5:0] int_enable,
   input wire int_clear_wr,
   input wire [5:0] int_clear_data,
   output reg [2:0] backlight_level_code,
   output reg [3:0] level_main_q,
   output reg [3:0] level_second_q,
   output reg [6:0] backlight_group,
   output reg [6:0] independent_on,
   output reg [48:0] independent_current,
   output reg [6:0] seventh_current,
   output reg seventh_ambient_active,
   output reg [3:0] fade_in_out,
   output reg [3:0] fade_out_out,
   output reg fade_law_out,
   output reg pump_enable,
   output reg sinks_enable,
   output reg low_current,
   output reg short_sense_enable,
   output reg [2:0] fault_state,
   output reg [5:0] int_status,
   output wire interrupt_pin_low_out,
   output wire interrupt_pin_low_oe
);
   // ****************************************
   // millisecond tick
   // ****************************************
   // all long times count in ms ticks so counters stay narrow
   reg [31:0] tick_cnt_q;
   reg ms_tick_q;

   always @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tick_cnt_q <= 32'h00000000;
         ms_tick_q <= 1'b0;
      end
      else if (tick_cnt_q >= MS_CYCLES - 1)
      begin
         tick_cnt_q <= 32'h00000000;
         ms_tick_q <= 1'b1;
      end
      else
      begin
         tick_cnt_q <= tick_cnt_q + 32'h00000001;
         ms_tick_q <= 1'b0;
      end
   end

   // ****************************************
   // comparator filtering and level code
   // ****************************************
   reg [13:0] filter_ms;
   wire [3:0] main_f;
   wire [3:0] second_f;

   always @*
   begin
      case (filter_sel)
         3'h0: filter_ms = `LSC_FILT_MIN_MS;
         3'h1: filter_ms = 14'h00A0;
         3'h2: filter_ms = 14'h0140;
         3'h3: filter_ms = 14'h0280;
         3'h4: filter_ms = 14'h0500;
         3'h5: filter_ms = 14'h0A00;
         3'h6: filter_ms = 14'h1400;
         default: filter_ms = `LSC_FILT_MAX_MS;
      endcase
   end

   lsc_level_filter #(.WIDTH(4)) u_filt_main (
      .mclk(mclk),
      .arst_n(arst_n),
      .ms_tick(ms_tick_q),
      .filter_ms(filter_ms),
      .level_raw(level_main_raw),
      .level_q(main_f)
   );

   lsc_level_filter #(.WIDTH(4)) u_filt_second (
      .mclk(mclk),
      .arst_n(arst_n),
      .ms_tick(ms_tick_q),
      .filter_ms(filter_ms),
      .level_raw(level_second_raw),
      .level_q(second_f)
   );

   // bit 3 is level five, bit 0 level two
   function [2:0] level_encode;
      input [3:0] lv;
      begin
         if (lv[3])
            level_encode = 3'h4;
         else if (lv[2])
            level_encode = 3'h3;
         else if (lv[1])
            level_encode = 3'h2;
         else if (lv[0])
            level_encode = 3'h1;
         else
            level_encode = 3'h0;
      end
   endfunction

   wire [2:0] main_code;
   wire seventh_amb;
   reg [6:0] seventh_sel;

   assign main_code = level_encode(main_f);
   assign seventh_amb = seventh_sink_ambient_enable
      & seventh_sink_independent_select[6];

   always @*
   begin
      case (main_code)
         3'h0: seventh_sel = seventh_level0;
         3'h1: seventh_sel = seventh_level1;
         3'h2: seventh_sel = seventh_level2;
         3'h3: seventh_sel = seventh_level3;
         default: seventh_sel = seventh_level4;
      endcase
   end

   // ****************************************
   // independent sinks
   // ****************************************
   wire [6:0] blink_on;
   genvar gi;
   generate
      for (gi = 0; gi < `LSC_NSINKS; gi = gi + 1)
      begin : g_sink
         lsc_blink u_blink (
            .mclk(mclk),
            .arst_n(arst_n),
            .ms_tick(ms_tick_q),
            .enable(sink_enable_bit[gi] & seventh_sink_independent_select[gi]),
            .on_code(shared_on_timer),
            .off_code(sink_off_timer[2*gi+1:2*gi]),
            .sink_on(blink_on[gi])
         );
      end
   endgenerate

   always @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         backlight_level_code <= 3'h0;
         level_main_q <= 4'h0;
         level_second_q <= 4'h0;
         backlight_group <= 7'h00;
         independent_on <= 7'h00;
         independent_current <= 49'h0;
         seventh_current <= 7'h00;
         seventh_ambient_active <= 1'b0;
         fade_in_out <= 4'h0;
         fade_out_out <= 4'h0;
         fade_law_out <= 1'b0;
      end
      else
      begin
         backlight_level_code <= auto_level_enable ? main_code : manual_level_code;
         level_main_q <= main_f;
         level_second_q <= second_f;
         backlight_group <= ~seventh_sink_independent_select;
         independent_on <= blink_on & {7{sinks_enable}};
         independent_current <= sink_current;
         seventh_current <= seventh_amb ? seventh_sel : sink_current[48:42];
         seventh_ambient_active <= seventh_amb;
         fade_in_out <= fade_in_code;
         fade_out_out <= fade_out_code;
         fade_law_out <= fade_law;
      end
   end

   // ****************************************
   // fault state machine
   // ****************************************
   localparam ST_STANDBY = `LSC_ST_STANDBY;
   localparam ST_SOFT = `LSC_ST_SOFT;
   localparam ST_RUN = `LSC_ST_RUN;
   localparam ST_SHORT = `LSC_ST_SHORT;
   localparam ST_THERMAL = `LSC_ST_THERMAL;

   // analog detectors are asynchronous: three stages, second and third agree
   reg [3:0] fs1_q;
   reg [3:0] fs2_q;
   reg [3:0] fs3_q;
   reg [3:0] fdet_q;
   reg [2:0] state_q;
   reg [10:0] mask_cnt_q;
   reg ovp_prev_q;
   wire short_s;
   wire ovp_s;
   wire hot_s;
   wire cool_s;

   assign short_s = fdet_q[0];
   assign ovp_s = fdet_q[1];
   assign hot_s = fdet_q[2];
   assign cool_s = fdet_q[3];

   always @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         fs1_q <= 4'h0;
         fs2_q <= 4'h0;
         fs3_q <= 4'h0;
         fdet_q <= 4'h0;
      end
      else
      begin
         fs1_q <= {cooled_detect, overtemp_detect, overvoltage_detect, short_detect};
         fs2_q <= fs1_q;
         fs3_q <= fs2_q;
         fdet_q <= (fs3_q & ~(fs2_q ^ fs3_q)) | (fdet_q & (fs2_q ^ fs3_q));
      end
   end

   always @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_q <= ST_STANDBY;
         mask_cnt_q <= 11'h000;
      end
      else if (hot_s && state_q != ST_THERMAL)
         state_q <= ST_THERMAL;
      else
      begin
         case (state_q)
            ST_STANDBY:
            begin
               mask_cnt_q <= 11'h000;
               if (standby_release_bit)
                  state_q <= ST_SOFT;
            end
            ST_SOFT:
            begin
               if (standby_enter)
                  state_q <= ST_STANDBY;
               else if (mask_cnt_q >= `LSC_SHORT_MASK_MS)
                  state_q <= ST_RUN;
               else if (ms_tick_q)
                  mask_cnt_q <= mask_cnt_q + 11'h001;
            end
            ST_RUN:
            begin
               if (standby_enter)
                  state_q <= ST_STANDBY;
               else if (short_s)
                  state_q <= ST_SHORT;
            end
            ST_SHORT:
            begin
               mask_cnt_q <= 11'h000;
               if (standby_release_bit)
                  state_q <= ST_SOFT;
            end
            ST_THERMAL:
            begin
               mask_cnt_q <= 11'h000;
               if (standby_release_bit && cool_s)
                  state_q <= ST_SOFT;
            end
            default:
               state_q <= ST_STANDBY;
         endcase
      end
   end

   always @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pump_enable <= 1'b0;
         sinks_enable <= 1'b0;
         low_current <= 1'b0;
         short_sense_enable <= 1'b0;
         fault_state <= ST_STANDBY;
      end
      else
      begin
         // pump pauses on overvoltage while sinks keep running
         pump_enable <= (state_q == ST_SOFT || state_q == ST_RUN) && !ovp_s;
         sinks_enable <= (state_q == ST_SOFT || state_q == ST_RUN);
         low_current <= (state_q == ST_SHORT);
         short_sense_enable <= (state_q == ST_RUN);
         fault_state <= state_q;
      end
   end

   // ****************************************
   // interrupt flags
   // ****************************************
   reg [3:0] main_prev_q;
   reg [3:0] second_prev_q;
   reg [5:0] flag_set;

   always @*
   begin
      flag_set = 6'h00;
      flag_set[`LSC_F_BLOFF] = backlight_fade_done;
      flag_set[`LSC_F_CMP] = (main_f != main_prev_q);
      flag_set[`LSC_F_CMP2] = (second_f != second_prev_q);
      flag_set[`LSC_F_OVP] = ovp_s & ~ovp_prev_q;
      // level set: a clear while still hot sets it again
      flag_set[`LSC_F_TSD] = hot_s;
      flag_set[`LSC_F_SHORT] = (state_q == ST_RUN) & short_s;
   end

   always @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         main_prev_q <= 4'h0;
         second_prev_q <= 4'h0;
         ovp_prev_q <= 1'b0;
         int_status <= 6'h00;
      end
      else
      begin
         main_prev_q <= main_f;
         second_prev_q <= second_f;
         ovp_prev_q <= ovp_s;
         // set wins over a same-cycle clear
         int_status <= (int_status & ~({6{int_clear_wr}} & int_clear_data))
            | flag_set;
      end
   end

   // open drain: drive low only while an enabled flag is pending
   assign interrupt_pin_low_out = 1'b0;
   assign interrupt_pin_low_oe = |(int_status & int_enable);

endmodule // lsc_ctrl

// ===== tb/lsc_ctrl_assertions.sv
// assertion checker of the led sink control block
`include "lsc_consts.vh"
module lsc_chk #(
   parameter MS_CYCLES = `LSC_MS_CYCLES
) (
   input wire mclk,
   input wire arst_n,
   input wire auto_level_enable,
   input wire [2:0] manual_level_code,
   input wire seventh_sink_ambient_enable,
   input wire [6:0] seventh_sink_independent_select,
   input wire short_detect,
   input wire overvoltage_detect,
   input wire overtemp_detect,
   input wire backlight_fade_done,
   input wire [5:0] int_enable,
   input wire int_clear_wr,
   input wire [5:0] int_clear_data,
   input wire [2:0] backlight_level_code,
   input wire [3:0] level_main_q,
   input wire [6:0] backlight_group,
   input wire [6:0] independent_on,
   input wire seventh_ambient_active,
   input wire pump_enable,
   input wire short_sense_enable,
   input wire [2:0] fault_state,
   input wire [5:0] int_status,
   input wire interrupt_pin_low_out,
   input wire interrupt_pin_low_oe
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   reg [31:0] soft_cnt_q;
   function automatic [2:0] enc(input [3:0] v);
      enc = v[3] ? 3'h4 : v[2] ? 3'h3 : v[1] ? 3'h2 : v[0] ? 3'h1 : 3'h0;
   endfunction
   // cycles spent in soft start, judged when run is reached
   always @(posedge mclk or negedge arst_n)
      if (!arst_n)
         soft_cnt_q <= 32'h0;
      else
         soft_cnt_q <= (fault_state == `LSC_ST_SOFT) ? soft_cnt_q + 32'h1 : 32'h0;
   property p_auto; auto_level_enable && $past(auto_level_enable) |->
      backlight_level_code == enc(level_main_q); endproperty
   a_auto: assert property (p_auto) else $error("level code not priority");
   property p_manual; !auto_level_enable && $past(arst_n) && $stable(manual_level_code)
      |-> backlight_level_code == manual_level_code; endproperty
   a_manual: assert property (p_manual) else $error("manual code lost");
   property p_group; $past(arst_n) |->
      backlight_group == ~$past(seventh_sink_independent_select); endproperty
   a_group: assert property (p_group) else $error("group select wrong");
   property p_amb; $past(arst_n) |-> seventh_ambient_active ==
      ($past(seventh_sink_ambient_enable) & $past(seventh_sink_independent_select[6]));
   endproperty
   a_amb: assert property (p_amb) else $error("seventh ambient wrong");
   property p_ovp; overvoltage_detect [*8] |-> !pump_enable; endproperty
   a_ovp: assert property (p_ovp) else $error("pump kept on");
   property p_ovp_flag; $rose(overvoltage_detect) |-> ##[3:8] int_status[3]; endproperty
   a_ovp_flag: assert property (p_ovp_flag) else $error("ovp flag missing");
   property p_hot; overtemp_detect [*8] |->
      fault_state == `LSC_ST_THERMAL && int_status[4]; endproperty
   a_hot: assert property (p_hot) else $error("thermal not held");
   property p_short; (fault_state == `LSC_ST_RUN && short_detect) [*8] |-> 1'b0; endproperty
   a_short: assert property (p_short) else $error("short ignored in run");
   property p_mask; fault_state == `LSC_ST_SOFT && $past(fault_state) == `LSC_ST_SOFT
      |-> !short_sense_enable; endproperty
   a_mask: assert property (p_mask) else $error("short sensed in soft");
   property p_soft; fault_state == `LSC_ST_RUN && $past(fault_state) == `LSC_ST_SOFT
      |-> soft_cnt_q >= 3 * MS_CYCLES && soft_cnt_q <= 6 * MS_CYCLES; endproperty
   a_soft: assert property (p_soft) else $error("soft start length");
   property p_bloff; backlight_fade_done |=> int_status[0]; endproperty
   a_bloff: assert property (p_bloff) else $error("fade flag missing");
   property p_clear; int_clear_wr && int_clear_data[0] && !backlight_fade_done
      |=> !int_status[0]; endproperty
   a_clear: assert property (p_clear) else $error("flag not cleared");
   property p_pin; (interrupt_pin_low_oe == (|(int_status & int_enable)))
      && !interrupt_pin_low_out; endproperty
   a_pin: assert property (p_pin) else $error("pin mask wrong");
   c_hot: cover property (fault_state == `LSC_ST_THERMAL);
   c_short: cover property (fault_state == `LSC_ST_SHORT);
   c_blink: cover property ($fell(independent_on[0]));
endmodule // lsc_chk

bind lsc_ctrl lsc_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (.*);

// ===== tb/lsc_plant.sv
// far-side model: output rail and die temperature seen by the fault sensors
module lsc_plant #(
   parameter RAMP_CYCLES = 20
) (
   input wire mclk,
   input wire arst_n,
   input wire pump_enable,
   input wire vout_shorted,
   input wire vout_high,
   input wire die_heat,
   output wire short_detect,
   output wire overvoltage_detect,
   output wire overtemp_detect,
   output wire cooled_detect
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] temp_q;
   logic [15:0] rail_q;
   // rail reads low while charging, so an unmasked sensor would trip in soft start
   assign short_detect = vout_shorted | (rail_q < RAMP_CYCLES / 2);
   assign overvoltage_detect = vout_high;
   // trips at 150, cool below 130: the band between must refuse a restart
   assign overtemp_detect = temp_q >= 8'h96;
   assign cooled_detect = temp_q < 8'h82;
   always @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         temp_q <= 8'h19;
         rail_q <= 16'h0;
      end
      else
      begin
         if (die_heat && temp_q < 8'hA0)
            temp_q <= temp_q + 8'h1;
         else if (!die_heat && temp_q > 8'h19)
            temp_q <= temp_q - 8'h1;
         // rail held up by an overvoltage source even with the pump off
         if (pump_enable && rail_q < RAMP_CYCLES)
            rail_q <= rail_q + 16'h1;
         else if (!pump_enable && !vout_high && rail_q != 16'h0)
            rail_q <= rail_q - 16'h1;
      end
   end
endmodule // lsc_plant

// ===== tb/testbench.sv
// self-checking bench of the led sink control block
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int MS = 10;
   logic mclk = 0, arst_n = 0, auto_level_enable = 0, seventh_sink_ambient_enable = 1;
   logic fade_law = 1, standby_release_bit = 0, standby_enter = 0, backlight_fade_done = 0;
   logic int_clear_wr = 0, vout_shorted = 0, vout_high = 0, die_heat = 0;
   logic [2:0] manual_level_code = 3'h3, filter_sel = 3'h0;
   logic [3:0] level_main_raw = 0, level_second_raw = 0, fade_in_code = 4'h9;
   logic [3:0] fade_out_code = 4'h6;
   logic [6:0] seventh_sink_independent_select = 7'h43, sink_enable_bit = 0;
   logic [6:0] sev [0:4] = '{7'h11, 7'h12, 7'h13, 7'h14, 7'h15};
   logic [48:0] sink_current = {7'h2A, 42'h0};
   logic [1:0] shared_on_timer = 2'h0;
   logic [13:0] sink_off_timer = 14'h0001;
   logic [5:0] int_enable = 0, int_clear_data = 0;
   logic [3:0] row_raw [0:6] = '{4'h8, 4'hF, 4'h4, 4'h6, 4'h3, 4'h1, 4'h0};
   logic [2:0] row_code [0:6] = '{3'h4, 3'h4, 3'h3, 3'h3, 3'h2, 3'h1, 3'h0};
   wire short_detect, overvoltage_detect, overtemp_detect, cooled_detect;
   wire [2:0] backlight_level_code, fault_state;
   wire [3:0] level_main_q, level_second_q, fade_in_out, fade_out_out;
   wire [48:0] independent_current;
   wire [6:0] backlight_group, independent_on, seventh_current;
   wire seventh_ambient_active, fade_law_out, pump_enable, sinks_enable, low_current;
   wire short_sense_enable, interrupt_pin_low_out, interrupt_pin_low_oe;
   wire [5:0] int_status;
   int miscompares = 0;
   int check_count = 0;
   int i;
   lsc_plant #(.RAMP_CYCLES(2 * MS)) plant (.mclk, .arst_n, .pump_enable, .vout_shorted,
      .vout_high, .die_heat, .short_detect, .overvoltage_detect, .overtemp_detect, .cooled_detect);
   lsc_ctrl #(.MS_CYCLES(MS)) dut (.*, .seventh_level0(sev[0]), .seventh_level1(sev[1]),
      .seventh_level2(sev[2]), .seventh_level3(sev[3]), .seventh_level4(sev[4]));
   initial
   begin
      forever #2.5 mclk = ~mclk;
   end
   task conclude;
      if (miscompares == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input logic ok, input string msg);
      check_count++;
      if (ok !== 1'b1)
      begin
         miscompares++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task clr(input logic [5:0] d);
      @(posedge mclk);
      int_clear_wr <= 1'b1;
      int_clear_data <= d;
      @(posedge mclk);
      int_clear_wr <= 1'b0;
   endtask
   task rel;
      @(posedge mclk);
      standby_release_bit <= 1'b1;
      @(posedge mclk);
      standby_release_bit <= 1'b0;
   endtask
   // bounded wait; the check after it tells whether the state came
   task wait_st(input logic [2:0] s, input int lim);
      int k;
      for (k = 0; k < lim && fault_state !== s; k++)
         cyc(1);
   endtask
   initial
   begin
      #300000;
      miscompares++;
      conclude();
   end
   initial
   begin
      repeat (2) @(posedge mclk);
      arst_n <= 1'b1;
      cyc(3);
      chk({int_status, fault_state, interrupt_pin_low_oe} === 10'h000, "reset");
      chk(backlight_level_code === 3'h3, "manual code");
      chk(fade_in_out === 4'h9 && fade_out_out === 4'h6 && fade_law_out, "fade");
      chk(independent_current === sink_current, "currents");
      @(posedge mclk);
      auto_level_enable <= 1'b1;
      for (i = 0; i < 7; i++)
      begin
         clr(6'h3F);
         @(posedge mclk);
         level_main_raw <= row_raw[i];
         level_second_raw <= ~row_raw[i];
         cyc(1000);
         chk(level_main_q === row_raw[i], "filtered level");
         chk(level_second_q === ~row_raw[i], "second level");
         chk(backlight_level_code === row_code[i], "auto code");
         chk(seventh_current === sev[row_code[i]], "seventh level");
         chk(int_status[2:1] === 2'h3, "comparator flags");
      end
      clr(6'h3F);
      @(posedge mclk);
      level_main_raw <= 4'h2;
      cyc(700);
      chk(level_main_q === 4'h0, "early change");
      @(posedge mclk);
      level_main_raw <= 4'h0;
      cyc(1000);
      chk(level_main_q === 4'h0 && int_status[1] === 1'b0, "glitch passed");
      @(posedge mclk);
      seventh_sink_independent_select <= 7'h03;
      cyc(3);
      chk(!seventh_ambient_active && seventh_current === 7'h2A, "seventh own");
      chk(backlight_group === 7'h7C, "group");
      rel();
      wait_st(3'h2, 100);
      chk(fault_state === 3'h2 && int_status === 6'h0, "soft start");
      @(posedge mclk);
      vout_shorted <= 1'b1;
      wait_st(3'h3, 20);
      chk(int_status[5] === 1'b1 && low_current === 1'b1, "short");
      @(posedge mclk);
      vout_shorted <= 1'b0;
      clr(6'h20);
      rel();
      cyc(3);
      chk(fault_state === 3'h1 && short_sense_enable === 1'b0, "restart");
      wait_st(3'h2, 100);
      chk(short_sense_enable === 1'b1 && int_status[5] === 1'b0, "masked");
      @(posedge mclk);
      vout_high <= 1'b1;
      cyc(10);
      chk(!pump_enable && sinks_enable === 1'b1 && int_status[3] === 1'b1, "ovp");
      clr(6'h08);
      @(posedge mclk);
      vout_high <= 1'b0;
      cyc(10);
      chk(pump_enable === 1'b1 && fault_state === 3'h2, "ovp end");
      @(posedge mclk);
      die_heat <= 1'b1;
      wait_st(3'h4, 300);
      chk(fault_state === 3'h4 && int_status[4] === 1'b1 && !pump_enable, "hot");
      clr(6'h10);
      cyc(2);
      chk(int_status[4] === 1'b1, "hot reflag");
      @(posedge mclk);
      die_heat <= 1'b0;
      for (i = 0; i < 50 && overtemp_detect !== 1'b0; i++)
         @(posedge mclk);
      rel();
      cyc(3);
      chk(fault_state === 3'h4, "warm restart");
      for (i = 0; i < 100 && cooled_detect !== 1'b1; i++)
         @(posedge mclk);
      cyc(6);
      clr(6'h3F);
      cyc(2);
      chk(int_status === 6'h0, "cool flag");
      rel();
      cyc(3);
      chk(fault_state === 3'h1, "cool restart");
      wait_st(3'h2, 100);
      @(posedge mclk);
      backlight_fade_done <= 1'b1;
      int_enable <= 6'h01;
      @(posedge mclk);
      backlight_fade_done <= 1'b0;
      cyc(1);
      chk(int_status === 6'h01 && interrupt_pin_low_oe === 1'b1, "fade flag");
      @(posedge mclk);
      int_enable <= 6'h3E;
      cyc(1);
      chk(interrupt_pin_low_oe === 1'b0, "masked pin");
      clr(6'h01);
      cyc(1);
      chk(int_status[0] === 1'b0, "flag clear");
      @(posedge mclk);
      sink_enable_bit <= 7'h03;
      cyc(3);
      chk(independent_on[1:0] === 2'h3, "blink start");
      cyc(2100);
      chk(independent_on[1:0] === 2'h2, "on time");
      cyc(6000);
      chk(independent_on[1:0] === 2'h3, "off time");
      cyc(1000);
      @(posedge mclk);
      sink_enable_bit <= 7'h02;
      cyc(3);
      chk(independent_on[1:0] === 2'h2, "drop in on");
      @(posedge mclk);
      sink_enable_bit <= 7'h03;
      cyc(2100);
      @(posedge mclk);
      sink_enable_bit <= 7'h02;
      cyc(6500);
      chk(independent_on[1:0] === 2'h2, "drop in off");
      @(posedge mclk);
      standby_enter <= 1'b1;
      @(posedge mclk);
      standby_enter <= 1'b0;
      cyc(3);
      chk(fault_state === 3'h0 && !pump_enable, "standby");
      conclude();
   end
endmodule // testbench
